// file: design/fspc_seq.sv
/*
 * fspc_seq: flash self-programming sequencer with AXI4-Lite registers.
 * Assumes a simple flash array port (combinational read data) and a RAM port
 * for source words; caller context (fetch location, status word bits) as inputs.
 */
`default_nettype none
module fspc_seq
	import fspc_pkg::*;
#(
	parameter int AW = 20
) (
	input  wire logic          sys_clk_i,
	input  wire logic          srst_i,
	// AXI4-Lite slave
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// caller context
	input  wire logic          exec_in_flash_i,
	input  wire logic          nmi_pending_bit_i,
	input  wire logic          interrupt_disable_bit_i,
	input  wire logic          nmi_i,
	// flash array
	output logic [AW-1:0]      fl_addr_o,
	output logic [31:0]        fl_wdata_o,
	output logic               fl_prog_o,
	output logic               fl_erase_o,
	input  wire logic [31:0]   fl_rdata_i,
	// ram source
	output logic [AW-1:0]      ram_addr_o,
	input  wire logic [31:0]   ram_rdata_i
);
	initial begin
		if (AW < 8 || AW > 32) $error("fspc_seq: AW out of range");
	end
	logic              mode_q;
	logic [4:0]        func_q;
	logic [31:0]       arg1_q, arg2_q, arg3_q;
	logic [15:0]       twrite_q, terase_q;
	logic [7:0]        result_q;
	logic              busy_q, done_q, nmi_flag_q;
	logic              fail_q;
	logic [31:0]       cnt_q;
	logic [AW-1:0]     addr_q, src_q;
	logic [AW-1:0]     er_base_q;
	logic [31:0]       er_len_q;
	fspc_state_t       st_q;
	logic              go;
	logic              step_start, step_done;
	logic [15:0]       step_len;
	// write channel latches, either order accepted
	logic              aw_q, w_q;
	logic [7:0]        awa_q;
	logic [31:0]       wd_q;
	logic [3:0]        ws_q;
	logic              wr_fire;
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign wr_fire = aw_q && w_q && !s_axi_bvalid;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			aw_q  <= 1'b0;
			w_q   <= 1'b0;
			awa_q <= 8'h00;
			wd_q  <= 32'h0000_0000;
			ws_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q  <= 1'b1;
				awa_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_q <= 1'b0;
			end
		end
	end
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge
	// write decode; FUNC write while idle launches a call
	logic wr_ok;
	always_comb begin
		unique case (awa_q)
			FSPC_OFS_MODE, FSPC_OFS_FUNC, FSPC_OFS_ARG1, FSPC_OFS_ARG2, FSPC_OFS_ARG3,
			FSPC_OFS_TWRITE, FSPC_OFS_TERASE, FSPC_OFS_STATUS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	assign go = wr_fire && (awa_q == FSPC_OFS_FUNC) && !busy_q;
	// write response
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= FSPC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? FSPC_RESP_OKAY : FSPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// MODE, TWRITE and TERASE take their strobed bytes from a full merged word
	logic [31:0] mode_mrg, tw_mrg, te_mrg;
	assign mode_mrg = merge({31'h0, mode_q}, wd_q, ws_q);
	assign tw_mrg   = merge({16'h0, twrite_q}, wd_q, ws_q);
	assign te_mrg   = merge({16'h0, terase_q}, wd_q, ws_q);
	// software registers; config held while a call runs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mode_q   <= 1'b0;
			func_q   <= 5'h00;
			arg1_q   <= 32'h0000_0000;
			arg2_q   <= 32'h0000_0000;
			arg3_q   <= 32'h0000_0000;
			twrite_q <= 16'h0001;
			terase_q <= 16'h0001;
		end else if (wr_fire && !busy_q) begin
			unique case (awa_q)
				FSPC_OFS_MODE:   mode_q   <= mode_mrg[0];
				FSPC_OFS_FUNC:   func_q   <= wd_q[4:0];
				FSPC_OFS_ARG1:   arg1_q   <= merge(arg1_q, wd_q, ws_q);
				FSPC_OFS_ARG2:   arg2_q   <= merge(arg2_q, wd_q, ws_q);
				FSPC_OFS_ARG3:   arg3_q   <= merge(arg3_q, wd_q, ws_q);
				FSPC_OFS_TWRITE: twrite_q <= tw_mrg[15:0];
				FSPC_OFS_TERASE: terase_q <= te_mrg[15:0];
				default: ;
			endcase
		end
	end
	// read channel
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		unique case (s_axi_araddr)
			FSPC_OFS_MODE:   rd = {31'h0, mode_q};
			FSPC_OFS_FUNC:   rd = {27'h0, func_q};
			FSPC_OFS_ARG1:   rd = arg1_q;
			FSPC_OFS_ARG2:   rd = arg2_q;
			FSPC_OFS_ARG3:   rd = arg3_q;
			FSPC_OFS_TWRITE: rd = {16'h0, twrite_q};
			FSPC_OFS_TERASE: rd = {16'h0, terase_q};
			FSPC_OFS_STATUS: rd = {29'h0, nmi_flag_q, done_q, busy_q};
			FSPC_OFS_RESULT: rd = {24'h0, result_q};
			FSPC_OFS_INFO:   rd = FSPC_INFO_WORD;
			default: ;
		endcase
	end
	logic rd_map;
	assign rd_map = (s_axi_araddr <= FSPC_OFS_INFO) && (s_axi_araddr[1:0] == 2'b00);
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= FSPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd;
			s_axi_rresp  <= rd_map ? FSPC_RESP_OKAY : FSPC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// timed step generator
	fspc_tick u_tick (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.start_i   (step_start),
		.len_i     (step_len),
		.done_o    (step_done)
	);
	localparam int BYTE_SHIFT = 2; // byte counts become word counts
	logic is_erase_fn;
	assign is_erase_fn = (func_q == FSPC_FN_ERASE) || (func_q == FSPC_FN_WRBACK);
	assign step_len   = is_erase_fn ? terase_q : twrite_q;
	assign step_start = (st_q == FSPC_RUN) && (fl_prog_o || fl_erase_o);
	// flash port driven only in RUN; a refused call never reaches it
	always_comb begin
		fl_addr_o  = addr_q;
		fl_wdata_o = 32'h0000_0000;
		fl_prog_o  = 1'b0;
		fl_erase_o = 1'b0;
		ram_addr_o = src_q;
		if (st_q == FSPC_RUN && cnt_q != 32'h0000_0000) begin // a spent count must not pulse again
			unique case (func_q)
				FSPC_FN_ERASE:  fl_erase_o = 1'b1;
				FSPC_FN_WRBACK: fl_prog_o  = 1'b1;
				FSPC_FN_PREWR:  fl_prog_o  = 1'b1;
				FSPC_FN_WORDWR: begin
					fl_prog_o  = 1'b1;
					fl_wdata_o = ram_rdata_i;
				end
				default: ;
			endcase
			if (func_q == FSPC_FN_WRBACK) fl_wdata_o = 32'hFFFF_FFFF;
		end
	end
	// call sequencer
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q      <= FSPC_IDLE;
			busy_q    <= 1'b0;
			done_q    <= 1'b0;
			result_q  <= FSPC_RES_OK;
			fail_q    <= 1'b0;
			cnt_q     <= 32'h0000_0000;
			addr_q    <= '0;
			src_q     <= '0;
			er_base_q <= '0;
			er_len_q  <= 32'h0000_0000;
		end else begin
			unique case (st_q)
				FSPC_IDLE: if (go) begin
					st_q   <= FSPC_CHECK;
					busy_q <= 1'b1;
					done_q <= 1'b0;
					fail_q <= 1'b0;
				end
				FSPC_CHECK: begin
					st_q <= FSPC_FINISH;
					if (!mode_q) result_q <= FSPC_RES_NOMODE;
					else if (exec_in_flash_i) result_q <= FSPC_RES_FROMFL;
					else if (!nmi_pending_bit_i && interrupt_disable_bit_i)
						result_q <= FSPC_RES_INISR;
					else begin
						result_q <= FSPC_RES_OK;
						unique case (func_q)
							FSPC_FN_INFO: result_q <= FSPC_RES_OK;
							FSPC_FN_ERASE: begin
								addr_q    <= arg1_q[AW-1:0];
								er_base_q <= arg1_q[AW-1:0];
								er_len_q  <= arg2_q;
								cnt_q     <= 32'h0000_0001; // whole area in one pulse
								st_q      <= FSPC_RUN;
							end
							FSPC_FN_WRBACK, FSPC_FN_ERVFY: begin
								addr_q <= er_base_q; // acts on last erased area
								cnt_q  <= er_len_q >> BYTE_SHIFT;
								st_q   <= FSPC_RUN;
							end
							FSPC_FN_BYTEVFY, FSPC_FN_PREWR, FSPC_FN_INTVFY: begin
								addr_q <= arg1_q[AW-1:0];
								cnt_q  <= arg2_q >> BYTE_SHIFT; // caller gives bytes
								st_q   <= FSPC_RUN;
							end
							FSPC_FN_WORDWR: begin
								addr_q <= arg1_q[AW-1:0];
								src_q  <= arg2_q[AW-1:0];
								cnt_q  <= arg3_q;
								st_q   <= FSPC_RUN;
							end
							default: result_q <= FSPC_RES_BADFN;
						endcase
					end
				end
				FSPC_RUN: begin
					if (cnt_q == 32'h0000_0000) begin
						st_q <= FSPC_FINISH;
					end else if (fl_prog_o || fl_erase_o) begin
						st_q <= FSPC_WAIT;
					end else begin
						// check functions compare one word every two cycles
						unique case (func_q)
							FSPC_FN_ERVFY: if (fl_rdata_i != 32'hFFFF_FFFF)
								fail_q <= 1'b1;
							FSPC_FN_BYTEVFY: if (fl_rdata_i != 32'hFFFF_FFFF)
								fail_q <= 1'b1;
							FSPC_FN_INTVFY: if (fl_rdata_i == 32'hFFFF_FFFF)
								fail_q <= 1'b1;
							default: ;
						endcase
						st_q <= FSPC_NEXT;
					end
				end
				FSPC_WAIT: if (step_done) st_q <= FSPC_NEXT;
				FSPC_NEXT: begin
					addr_q <= addr_q + AW'(4);
					src_q  <= src_q + AW'(4);
					cnt_q  <= (func_q == FSPC_FN_ERASE) ? 32'h0000_0000 : cnt_q - 32'h0000_0001;
					st_q   <= FSPC_RUN;
				end
				FSPC_FINISH: begin
					st_q   <= FSPC_IDLE;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					if (result_q == FSPC_RES_OK) begin
						if (nmi_flag_q) result_q <= FSPC_RES_NMI;
						else if (fail_q) result_q <= FSPC_RES_FAIL;
					end
				end
				default: st_q <= FSPC_IDLE;
			endcase
		end
	end
	// nmi sticky flag: set wins over software clear
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			nmi_flag_q <= 1'b0;
		end else if (busy_q && nmi_i) begin
			nmi_flag_q <= 1'b1;
		end else if (wr_fire && awa_q == FSPC_OFS_STATUS && ws_q[0] && wd_q[FSPC_ST_NMI]) begin
			nmi_flag_q <= 1'b0;
		end
	end
	refuse_flash_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(st_q == FSPC_CHECK && mode_q && exec_in_flash_i) |=> result_q == FSPC_RES_FROMFL)
		else $error("call from flash not refused");
	refuse_isr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(st_q == FSPC_CHECK && mode_q && !exec_in_flash_i && !nmi_pending_bit_i
		 && interrupt_disable_bit_i) |=> (result_q == FSPC_RES_INISR) ##1 !busy_q)
		else $error("call in interrupt servicing not refused");
	no_touch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(st_q == FSPC_CHECK && !mode_q) |=> (!fl_prog_o && !fl_erase_o)[*2])
		else $error("refused call touched flash");
	mode_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(fl_prog_o || fl_erase_o) |-> mode_q)
		else $error("flash driven outside self-programming mode");
	prewr_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(fl_prog_o && func_q == FSPC_FN_PREWR) |-> fl_wdata_o == 32'h0000_0000)
		else $error("prewrite data not zero");
	word_copy_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(fl_prog_o && func_q == FSPC_FN_WORDWR) |-> fl_wdata_o == ram_rdata_i)
		else $error("word write data not from source");
	erase_area_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(st_q == FSPC_CHECK && mode_q && !exec_in_flash_i
		 && !(!nmi_pending_bit_i && interrupt_disable_bit_i) && func_q == FSPC_FN_ERASE)
		|=> fl_erase_o && fl_addr_o == $past(arg1_q[AW-1:0]))
		else $error("area erase not started at given address");
	nmi_flag_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(busy_q && nmi_i) |=> nmi_flag_q)
		else $error("nmi during processing not recorded");
	bad_fn_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(st_q == FSPC_CHECK && func_q == 5'h02 && mode_q && !exec_in_flash_i
		 && !(!nmi_pending_bit_i && interrupt_disable_bit_i)) |=> result_q == FSPC_RES_BADFN)
		else $error("reserved function accepted");
endmodule : fspc_seq
`default_nettype wire

// file: design/fspc_pkg.sv
/*
 * fspc_pkg: constants for the flash self-programming sequencer.
 * Assumes a 20 MHz system clock and an AXI4-Lite register port.
 */
// Behaviour
// - refuse calls issued from flash code
// - enter self-programming mode before any call
// - area erase clears the whole designated area; here one erase pulse at ARG1, ARG2 only kept for write back and erase verify
// - prewrite programs zeros before erase
// - erase verify reports over-erased cells; here it fails any word not all ones, as erase byte verify does
// - erase byte verify reports incomplete erasure
// - internal verify checks written cell margin; here it fails any word that still reads all ones
// - write back restores over-erased area
// - information read returns flash description; here function 0 only returns OK and the INFO register holds a fixed word
// - timings come from RAM parameter area; here from the TWRITE and TERASE registers
// - refuse calls during interrupt servicing
// - function numbers select the operation
// - record NMI in parameter flag, return value
`default_nettype none
package fspc_pkg;
	// register byte offsets
	localparam logic [7:0] FSPC_OFS_MODE   = 8'h00;
	localparam logic [7:0] FSPC_OFS_FUNC   = 8'h04;
	localparam logic [7:0] FSPC_OFS_ARG1   = 8'h08;
	localparam logic [7:0] FSPC_OFS_ARG2   = 8'h0C;
	localparam logic [7:0] FSPC_OFS_ARG3   = 8'h10;
	localparam logic [7:0] FSPC_OFS_TWRITE = 8'h14;
	localparam logic [7:0] FSPC_OFS_TERASE = 8'h18;
	localparam logic [7:0] FSPC_OFS_STATUS = 8'h1C;
	localparam logic [7:0] FSPC_OFS_RESULT = 8'h20;
	localparam logic [7:0] FSPC_OFS_INFO   = 8'h24;
	// function numbers
	localparam logic [4:0] FSPC_FN_INFO    = 5'h00;
	localparam logic [4:0] FSPC_FN_ERASE   = 5'h01;
	localparam logic [4:0] FSPC_FN_WRBACK  = 5'h05;
	localparam logic [4:0] FSPC_FN_BYTEVFY = 5'h09;
	localparam logic [4:0] FSPC_FN_ERVFY   = 5'h0A;
	localparam logic [4:0] FSPC_FN_WORDWR  = 5'h10;
	localparam logic [4:0] FSPC_FN_PREWR   = 5'h14;
	localparam logic [4:0] FSPC_FN_INTVFY  = 5'h15;
	// result codes
	localparam logic [7:0] FSPC_RES_OK       = 8'h00;
	localparam logic [7:0] FSPC_RES_FAIL     = 8'h01;
	localparam logic [7:0] FSPC_RES_NOMODE   = 8'h10;
	localparam logic [7:0] FSPC_RES_FROMFL   = 8'h11;
	localparam logic [7:0] FSPC_RES_INISR    = 8'h12;
	localparam logic [7:0] FSPC_RES_BADFN    = 8'h13;
	localparam logic [7:0] FSPC_RES_NMI      = 8'h14;
	// status bits
	localparam int FSPC_ST_BUSY = 0;
	localparam int FSPC_ST_DONE = 1;
	localparam int FSPC_ST_NMI  = 2;
	// timing
	localparam int FSPC_CLK_HZ  = 20_000_000;
	localparam int FSPC_TICK_NS = 1_000;
	localparam int FSPC_TICK_CYC = (FSPC_TICK_NS * (FSPC_CLK_HZ / 1_000_000)) / 1_000;
	// bus responses
	localparam logic [1:0] FSPC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] FSPC_RESP_SLVERR = 2'b10;
	// info word, arbitrary value
	localparam logic [31:0] FSPC_INFO_WORD = 32'h0001_0000;
	typedef enum logic [2:0] {
		FSPC_IDLE, FSPC_CHECK, FSPC_RUN, FSPC_WAIT, FSPC_NEXT, FSPC_FINISH
	} fspc_state_t;
endpackage : fspc_pkg
`default_nettype wire

// file: design/fspc_tick.sv
/*
 * fspc_tick: microsecond tick divider and timed step counter.
 * Assumes one clock; start begins a wait of len ticks, done pulses at end.
 */
`default_nettype none
module fspc_tick
	import fspc_pkg::*;
#(
	parameter int DIV = FSPC_TICK_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        start_i,
	input  wire logic [15:0] len_i,
	output logic             done_o
);
	initial begin
		if (DIV < 1) $error("fspc_tick: DIV must be at least 1");
	end
	logic [15:0] div_q;
	logic [15:0] cnt_q;
	logic        run_q;
	logic        tick;
	assign tick = (div_q == 16'(DIV - 1));
	// prescaler, free running, so the step time can fall up to one tick short of len
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	// step counter
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			run_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (start_i) begin
			run_q <= 1'b1;
			cnt_q <= len_i;
		end else if (run_q && (cnt_q == 16'h0000)) begin
			run_q <= 1'b0;
		end else if (run_q && tick) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	assign done_o = run_q && (cnt_q == 16'h0000) && !start_i;
endmodule : fspc_tick
`default_nettype wire

// file: verification/fspc_flash_model.sv
/*
 * fspc_flash_model: behavioural flash array and source RAM facing fspc_seq.
 * Assumes byte addresses on both ports and combinational read data.
 */
`default_nettype none
module fspc_flash_model
	import fspc_pkg::*;
#(
	parameter int AW          = 20,
	parameter int ERASE_WORDS = 16
) (
	input  wire logic          sys_clk_i,
	input  wire logic [AW-1:0] fl_addr_i,
	input  wire logic [31:0]   fl_wdata_i,
	input  wire logic          fl_prog_i,
	input  wire logic          fl_erase_i,
	output logic [31:0]        fl_rdata_o,
	input  wire logic [AW-1:0] ram_addr_i,
	input  wire logic [31:0]   seed_i,
	input  wire logic          vpp_i,
	output logic [31:0]        ram_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [64];
	logic [5:0]  idx;

	// non-blank start contents, so that a missed erase shows up
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 32'hA5A5_0000 | i;
		end
	end

	assign idx = fl_addr_i[7:2];

	// erase clears a fixed block of words, program stores one word
	always @(posedge sys_clk_i) begin
		// cells only change with programming voltage applied
		if (fl_erase_i && vpp_i) begin
			for (int i = 0; i < ERASE_WORDS; i++) begin
				mem[6'(idx + i)] <= 32'hFFFF_FFFF;
			end
		end else if (fl_prog_i && vpp_i) begin
			mem[idx] <= fl_wdata_i;
		end
	end

	assign fl_rdata_o  = mem[idx];
	assign ram_rdata_o = 32'(ram_addr_i) ^ seed_i; // source words vary with address and seed
endmodule : fspc_flash_model
`default_nettype wire

// file: verification/fspc_seq_tb_top.sv
/*
 * fspc_seq_tb_top: self-checking bench for fspc_seq over AXI4-Lite.
 * Assumes the flash model above and TWRITE = TERASE = 1 us.
 */
`default_nettype none
module fspc_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fspc_pkg::*;

	logic        clk = 0;
	logic        srst = 1;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, seed = 0, rdata, flw, flr, ramd;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, prog, erase;
	logic [1:0]  bresp, rresp;
	logic        in_fl = 0, nmi_pend = 1, idb = 0, nmi = 0;
	logic        vpp = 0; // programming voltage off through reset release
	int          rsv [11] = '{2, 3, 4, 6, 8, 11, 15, 17, 19, 22, 31};
	logic [19:0] fla, rama;
	int          fails = 0, n_tests = 0;
	logic [31:0] lf = 32'd91, d;
	logic [1:0]  r;
	int          n, src;

	fspc_seq i_dut (.sys_clk_i(clk), .srst_i(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .exec_in_flash_i(in_fl), .nmi_pending_bit_i(nmi_pend),
		.interrupt_disable_bit_i(idb), .nmi_i(nmi), .fl_addr_o(fla), .fl_wdata_o(flw),
		.fl_prog_o(prog), .fl_erase_o(erase), .fl_rdata_i(flr), .ram_addr_o(rama),
		.ram_rdata_i(ramd));
	fspc_flash_model i_flash (.sys_clk_i(clk), .fl_addr_i(fla), .fl_wdata_i(flw),
		.fl_prog_i(prog), .fl_erase_i(erase), .fl_rdata_o(flr), .ram_addr_i(rama),
		.seed_i(seed), .vpp_i(vpp), .ram_rdata_o(ramd));

	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude

	// one write; each channel released at its own handshake edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		awaddr <= a; wdata <= v; wstrb <= 4'hF;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid === 1'b1) break;
		end
		bready <= 0;
		if (k >= 200) chk("write wait", 0, 1);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		rs = rresp;
		rready <= 0;
		if (k >= 200) chk("read wait", 0, 1);
	endtask : axi_rd

	// launch a function, optionally with an nmi, then poll busy and fetch the result
	task automatic call(input logic [4:0] fn, input logic [7:0] exp, input bit with_nmi);
		logic [31:0] v;
		logic [1:0]  rs;
		int          k;
		axi_wr(FSPC_OFS_FUNC, 32'(fn));
		if (with_nmi) begin
			nmi <= 1;
			repeat (6) @(posedge clk);
			nmi <= 0;
		end
		repeat (4) @(posedge clk);
		for (k = 0; k < 5000; k++) begin
			axi_rd(FSPC_OFS_STATUS, v, rs);
			if (v[FSPC_ST_BUSY] === 1'b0) break;
		end
		chk("idle", 32'(k < 5000), 1);
		chk("done", 32'(v[FSPC_ST_DONE]), 1);
		axi_rd(FSPC_OFS_RESULT, v, rs);
		if (exp !== 8'hFF) chk("result", v, 32'(exp));
	endtask : call

	task automatic area(input logic [7:0] a1, input logic [31:0] a2);
		axi_wr(FSPC_OFS_ARG1, 32'(a1));
		axi_wr(FSPC_OFS_ARG2, a2);
	endtask : area

	task automatic flash_is(input logic [31:0] v);
		for (int i = 16; i < 32; i++) chk("flash word", i_flash.mem[i], v);
	endtask : flash_is

	// watchdog sized well above the longest expected run
	initial begin
		repeat (80000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk);
		srst <= 0;
		axi_rd(FSPC_OFS_STATUS, d, r); chk("status", d, 0);
		axi_rd(FSPC_OFS_INFO, d, r); chk("info", d, FSPC_INFO_WORD);
		axi_rd(8'h40, d, r); chk("unmapped", {d[29:0], r}, {30'h0, FSPC_RESP_SLVERR});
		call(FSPC_FN_ERASE, FSPC_RES_NOMODE, 0);
		axi_wr(FSPC_OFS_MODE, 32'h1);
		axi_wr(FSPC_OFS_TWRITE, 32'h1);
		axi_wr(FSPC_OFS_TERASE, 32'h1);
		axi_rd(FSPC_OFS_TWRITE, d, r); chk("twrite", d, 1);
		$display("test mode entry done");
		// refused calls leave the array alone; caller outside flash otherwise
		// caller in single-chip mode, interrupts enabled, no programmer
		area(8'h40, 32'h40);
		in_fl <= 1;
		call(FSPC_FN_ERASE, FSPC_RES_FROMFL, 0);
		in_fl <= 0;
		nmi_pend <= 0; idb <= 1;
		call(FSPC_FN_ERASE, FSPC_RES_INISR, 0);
		nmi_pend <= 1; idb <= 0;
		foreach (rsv[j]) begin
			call(5'(rsv[j]), FSPC_RES_BADFN, 0);
		end
		chk("untouched", i_flash.mem[16], 32'hA5A5_0010);
		$display("test refusals done");
		vpp <= 1; // voltage settled by the entry code before manipulation
		call(FSPC_FN_ERASE, FSPC_RES_OK, 0);
		flash_is(32'hFFFF_FFFF);
		call(FSPC_FN_ERVFY, FSPC_RES_OK, 0);
		call(FSPC_FN_BYTEVFY, FSPC_RES_OK, 0);
		$display("test erase done");
		// random word count and source, seed reaches the model's data
		lf = lfsr(lf);
		n = 1 + int'(lf[1:0]);
		lf = lfsr(lf);
		seed <= lf;
		src = int'(lf[15:8]) & 32'hFC;
		area(8'h40, 32'(src));
		axi_wr(FSPC_OFS_ARG3, 32'(n));
		call(FSPC_FN_WORDWR, FSPC_RES_OK, 0);
		for (int i = 0; i < n; i++) chk("word", i_flash.mem[16 + i], 32'(src + 4 * i) ^ seed);
		chk("past end", i_flash.mem[16 + n], 32'hFFFF_FFFF);
		area(8'h40, 32'(4 * n));
		call(FSPC_FN_INTVFY, FSPC_RES_OK, 0);
		area(8'h40, 32'h40);
		call(FSPC_FN_BYTEVFY, FSPC_RES_FAIL, 0);
		$display("test word write done");
		call(FSPC_FN_PREWR, FSPC_RES_OK, 0);
		flash_is(32'h0);
		call(FSPC_FN_WRBACK, 8'hFF, 0);
		flash_is(32'hFFFF_FFFF);
		call(FSPC_FN_INFO, 8'hFF, 0);
		$display("test prewrite and write back done");
		call(FSPC_FN_PREWR, FSPC_RES_NMI, 1);
		axi_rd(FSPC_OFS_STATUS, d, r); chk("nmi flag", 32'(d[FSPC_ST_NMI]), 1);
		axi_wr(FSPC_OFS_STATUS, 32'h4);
		axi_rd(FSPC_OFS_STATUS, d, r); chk("nmi clear", 32'(d[FSPC_ST_NMI]), 0);
		$display("test nmi done");
		vpp <= 0; // back to 0 V once manipulation is over
		conclude();
	end
endmodule : fspc_seq_tb_top
`default_nettype wire
